// >>> rtl/lec_status_readout.sv
// Lane error count and power mode status readout of the receive pattern verifier.
// Assumes all inputs come from logic on core_clk; the host reaches the registers
// through a simple byte-wide configuration port decoded upstream of this block.
`timescale 1ns/1ps

// Contract
// - Register 0x19 shows lane 0 count bits 11:8 in its low nibble, upper nibble reads zero, reset zero.
// - Lane 1 count is 12 bits, low byte at 0x1A and top nibble in the low nibble of 0x1B, both reset zero.
// - Lane 2 count is 12 bits, low byte at 0x1C and top nibble in the low nibble of 0x1D, both reset zero.
// - Lane 3 count is 12 bits, low byte at 0x1E and top nibble in the low nibble of 0x1F.
// - Counters update by hardware alone and host writes to them do nothing.
// - Bit 7 of 0x20 reads one in power-down and zero otherwise, reset zero.
// - Bit 6 of 0x20 reads one in standby and zero otherwise, bits 5:0 read zero.
// - Register 0x18 holds the low byte of the lane 0 count, completing it with 0x19.
// - A 3-bit selector picks the counted error: disparity, FIFO, overflow, underflow or deskew; others count nothing.
// - A rising edge of the clear control bit clears all lane counters to zero.
// - A lane counts only while its verify enable bit is set.
module lec_status_readout
    import lec_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // Clock, reset and enable
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             clkEn,
    // Configuration port
    input  wire logic [7:0]       regAddr,
    input  wire logic             regRdEn,
    input  wire logic             regWrEn,
    input  wire logic [7:0]       regWrData,
    output logic [7:0]            regRdData,
    output logic                  regRdValid,
    // Verifier controls
    input  wire logic [2:0]       errorSourceSelect,
    input  wire logic [LANES-1:0] laneVerifyEnable,
    input  wire logic             errorCountClear,
    // Per-lane error sources
    input  wire logic [LANES-1:0] disparityError,
    input  wire logic [LANES-1:0] fifoError,
    input  wire logic [LANES-1:0] fifoOverflow,
    input  wire logic [LANES-1:0] fifoUnderflow,
    input  wire logic [LANES-1:0] deskewEvent,
    // Power mode
    input  wire logic             powerdownMode,
    input  wire logic             standbyMode,
    // Status flags
    output logic                  powerdownFlag,
    output logic                  standbyFlag
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                   clearPrev_reg;
    logic                   clearPrev_next;
    logic                   powerdownFlag_reg;
    logic                   powerdownFlag_next;
    logic                   standbyFlag_reg;
    logic                   standbyFlag_next;
    logic [7:0]             regRdData_reg;
    logic [7:0]             regRdData_next;
    logic                   regRdValid_reg;
    logic                   regRdValid_next;
    logic                   clearPulse;
    logic [LANES-1:0]       laneErrorEvent;
    logic [LANES-1:0]       laneCountEn;
    logic [COUNT_WIDTH-1:0] laneErrorCount [LANES];
    logic                   writeIgnored;

    // ------------------------------------------------------------------
    // Error source selection
    // ------------------------------------------------------------------
    always_comb begin
        case (lec_source_e'(errorSourceSelect))
            SRC_DISPARITY: laneErrorEvent = disparityError;
            SRC_FIFO:      laneErrorEvent = fifoError;
            SRC_OVERFLOW:  laneErrorEvent = fifoOverflow;
            SRC_UNDERFLOW: laneErrorEvent = fifoUnderflow;
            SRC_DESKEW:    laneErrorEvent = deskewEvent;
            default:       laneErrorEvent = '0;
        endcase
    end

    assign laneCountEn = laneErrorEvent & laneVerifyEnable;
    assign clearPulse  = errorCountClear && !clearPrev_reg;

    // ------------------------------------------------------------------
    // Lane counters
    // ------------------------------------------------------------------
    for (genvar lane = 0; lane < LANES; lane++) begin : gLane
        lec_sat_counter #(
            .WIDTH   (COUNT_WIDTH)
        ) uCounter (
            .core_clk(core_clk),
            .rstn    (rstn),
            .clkEn   (clkEn),
            .clear   (clearPulse),
            .countEn (laneCountEn[lane]),
            .count   (laneErrorCount[lane])
        );
    end

    // ------------------------------------------------------------------
    // Register read and status next values
    // ------------------------------------------------------------------
    // Writes never reach counter or flag state; every field here is read-only.
    assign writeIgnored = regWrEn;

    always_comb begin
        clearPrev_next     = errorCountClear;
        powerdownFlag_next = powerdownMode;
        standbyFlag_next   = standbyMode;
        regRdValid_next    = regRdEn && !writeIgnored;
        regRdData_next     = regRdData_reg;
        if (regRdEn && !writeIgnored) begin
            case (regAddr)
                LANE0_ERROR_COUNT_LOW_OFS:
                    regRdData_next = laneErrorCount[0][LOW_BYTE_MSB:0];
                LANE0_ERROR_COUNT_HIGH_OFS:
                    regRdData_next = {RESERVED_NIBBLE, laneErrorCount[0][HIGH_NIBBLE_MSB:HIGH_NIBBLE_LSB]};
                LANE1_ERROR_COUNT_LOW_OFS:
                    regRdData_next = laneErrorCount[1][LOW_BYTE_MSB:0];
                LANE1_ERROR_COUNT_HIGH_OFS:
                    regRdData_next = {RESERVED_NIBBLE, laneErrorCount[1][HIGH_NIBBLE_MSB:HIGH_NIBBLE_LSB]};
                LANE2_ERROR_COUNT_LOW_OFS:
                    regRdData_next = laneErrorCount[2][LOW_BYTE_MSB:0];
                LANE2_ERROR_COUNT_HIGH_OFS:
                    regRdData_next = {RESERVED_NIBBLE, laneErrorCount[2][HIGH_NIBBLE_MSB:HIGH_NIBBLE_LSB]};
                LANE3_ERROR_COUNT_LOW_OFS:
                    regRdData_next = laneErrorCount[3][LOW_BYTE_MSB:0];
                LANE3_ERROR_COUNT_HIGH_OFS:
                    regRdData_next = {RESERVED_NIBBLE, laneErrorCount[3][HIGH_NIBBLE_MSB:HIGH_NIBBLE_LSB]};
                POWER_MODE_STATUS_OFS:
                    regRdData_next = {powerdownFlag_reg, standbyFlag_reg, RESERVED_STATUS};
                default:
                    regRdData_next = READ_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clearPrev_reg     <= FLAG_RESET;
            powerdownFlag_reg <= FLAG_RESET;
            standbyFlag_reg   <= FLAG_RESET;
            regRdData_reg     <= READ_RESET;
            regRdValid_reg    <= FLAG_RESET;
        end else if (clkEn) begin
            clearPrev_reg     <= clearPrev_next;
            powerdownFlag_reg <= powerdownFlag_next;
            standbyFlag_reg   <= standbyFlag_next;
            regRdData_reg     <= regRdData_next;
            regRdValid_reg    <= regRdValid_next;
        end
    end

    assign regRdData     = regRdData_reg;
    assign regRdValid    = regRdValid_reg;
    assign powerdownFlag = powerdownFlag_reg;
    assign standbyFlag   = standbyFlag_reg;

endmodule

// >>> rtl/lec_pkg.sv
// Package for the lane error count status readout.
// Assumes an 8-bit configuration register space addressed by byte offset.
package lec_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LANE0_ERROR_COUNT_LOW_OFS  = 8'h18;
    localparam logic [7:0] LANE0_ERROR_COUNT_HIGH_OFS = 8'h19;
    localparam logic [7:0] LANE1_ERROR_COUNT_LOW_OFS  = 8'h1A;
    localparam logic [7:0] LANE1_ERROR_COUNT_HIGH_OFS = 8'h1B;
    localparam logic [7:0] LANE2_ERROR_COUNT_LOW_OFS  = 8'h1C;
    localparam logic [7:0] LANE2_ERROR_COUNT_HIGH_OFS = 8'h1D;
    localparam logic [7:0] LANE3_ERROR_COUNT_LOW_OFS  = 8'h1E;
    localparam logic [7:0] LANE3_ERROR_COUNT_HIGH_OFS = 8'h1F;
    localparam logic [7:0] POWER_MODE_STATUS_OFS      = 8'h20;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int         COUNT_WIDTH      = 12;
    localparam int         LANE_COUNT       = 4;
    localparam int         LOW_BYTE_MSB     = 7;
    localparam int         HIGH_NIBBLE_MSB  = 11;
    localparam int         HIGH_NIBBLE_LSB  = 8;
    localparam int         POWERDOWN_BIT    = 7;
    localparam int         STANDBY_BIT      = 6;
    localparam logic [3:0] RESERVED_NIBBLE  = 4'h0;
    localparam logic [5:0] RESERVED_STATUS  = 6'h00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] COUNT_RESET     = 12'h000;
    localparam logic [7:0]  READ_RESET      = 8'h00;
    localparam logic        FLAG_RESET      = 1'b0;

    // ------------------------------------------------------------------
    // Error source selector codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_DISPARITY = 3'h0,
        SRC_FIFO      = 3'h1,
        SRC_OVERFLOW  = 3'h2,
        SRC_UNDERFLOW = 3'h3,
        SRC_DESKEW    = 3'h4
    } lec_source_e;

endpackage

// >>> rtl/lec_sat_counter.sv
// One lane's saturating error counter.
// Assumes clear and count come from logic on the same clock.
`timescale 1ns/1ps

module lec_sat_counter
    import lec_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             clkEn,
    // Control
    input  wire logic             clear,
    input  wire logic             countEn,
    // Count value
    output logic [WIDTH-1:0]      count
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = '0;
        end else if (countEn && (count_reg != {WIDTH{1'b1}})) begin
            count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (clkEn) begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

// >>> verif/lec_status_readout_sva.sv
// Checker for the lane error count and power status readout.
// Assumes every port is sampled on the rising edge of core_clk.
`timescale 1ns/1ps
module lec_status_readout_sva (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       clkEn,
    input wire logic [7:0] regAddr,
    input wire logic       regRdEn,
    input wire logic       regWrEn,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic       errorCountClear,
    input wire logic       powerdownMode,
    input wire logic       standbyMode,
    input wire logic       powerdownFlag,
    input wire logic       standbyFlag
);
    logic rdTake;
    assign rdTake = clkEn && regRdEn && !regWrEn;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (rdTake |=> regRdValid)
        else $error("read not answered");
    a_idle_quiet: assert property (clkEn && !rdTake |=> !regRdValid && $stable(regRdData))
        else $error("answer without read");
    a_write_silent: assert property (clkEn && regWrEn |=> !regRdValid)
        else $error("write answered");
    a_high_reserved: assert property (rdTake && regAddr inside {8'h19, 8'h1B, 8'h1D, 8'h1F}
        |=> regRdData[7:4] == 4'h0) else $error("reserved nibble set");
    a_status_byte: assert property (rdTake && regAddr == 8'h20
        |=> regRdData == {$past(powerdownFlag), $past(standbyFlag), 6'h00}) else $error("status byte wrong");
    a_pdown_follow: assert property (clkEn |=> powerdownFlag == $past(powerdownMode))
        else $error("power-down flag wrong");
    a_stby_follow: assert property (clkEn |=> standbyFlag == $past(standbyMode))
        else $error("standby flag wrong");
    a_clear_zero: assert property (clkEn && errorCountClear && !$past(errorCountClear)
        ##1 rdTake && regAddr inside {[8'h18:8'h1F]} |=> regRdData == 8'h00) else $error("count not cleared");
endmodule
bind lec_status_readout lec_status_readout_sva chk (.core_clk, .rstn, .clkEn, .regAddr, .regRdEn, .regWrEn,
    .regRdData, .regRdValid, .errorCountClear, .powerdownMode, .standbyMode, .powerdownFlag, .standbyFlag);

// >>> verif/lec_host_model.sv
// Host model reaching the readout through its byte configuration port.
// Assumes its tasks are called just after a falling edge of core_clk.
`timescale 1ns/1ps
module lec_host_model (
    // Clock
    input  wire logic       core_clk,
    // Configuration port
    output logic [7:0]      regAddr,
    output logic            regRdEn,
    output logic            regWrEn,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid,
    // Clear control bit
    output logic            errorCountClear
);
    initial begin
        regAddr = 8'h00;
        regRdEn = 1'b0;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        errorCountClear = 1'b0;
    end
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
        v = regRdValid;
        @(negedge core_clk);
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        regWrData = ~d;
        @(negedge core_clk);
    endtask
    // Host writes the clear bit; a 0 to 1 change clears the counters
    task automatic setClear(input logic b);
        errorCountClear = b;
        @(negedge core_clk);
    endtask
endmodule

// >>> verif/lane_error_count_status_readout_tb_top.sv
// Testbench for the lane error count and power status readout.
// Assumes the host model drives the configuration port and clear bit.
`timescale 1ns/1ps
module lane_error_count_status_readout_tb_top;
    import lec_pkg::*;
    logic core_clk = 1'b0;
    logic rstn, clkEn, powerdownMode, standbyMode;
    logic [7:0] regAddr, regWrData, regRdData;
    logic regRdEn, regWrEn, regRdValid, errorCountClear, powerdownFlag, standbyFlag;
    logic [2:0] errorSourceSelect;
    logic [3:0] laneVerifyEnable, disparityError, fifoError, fifoOverflow, fifoUnderflow, deskewEvent;
    logic [19:0] ev = 20'h00000;
    int num_errors = 0, checks = 0, cyc = 0;
    assign {deskewEvent, fifoUnderflow, fifoOverflow, fifoError, disparityError} = ev;
    lec_status_readout dut (
        .core_clk         (core_clk),
        .rstn             (rstn),
        .clkEn            (clkEn),
        .regAddr          (regAddr),
        .regRdEn          (regRdEn),
        .regWrEn          (regWrEn),
        .regWrData        (regWrData),
        .regRdData        (regRdData),
        .regRdValid       (regRdValid),
        .errorSourceSelect(errorSourceSelect),
        .laneVerifyEnable (laneVerifyEnable),
        .errorCountClear  (errorCountClear),
        .disparityError   (disparityError),
        .fifoError        (fifoError),
        .fifoOverflow     (fifoOverflow),
        .fifoUnderflow    (fifoUnderflow),
        .deskewEvent      (deskewEvent),
        .powerdownMode    (powerdownMode),
        .standbyMode      (standbyMode),
        .powerdownFlag    (powerdownFlag),
        .standbyFlag      (standbyFlag)
    );
    lec_host_model host (
        .core_clk         (core_clk),
        .regAddr          (regAddr),
        .regRdEn          (regRdEn),
        .regWrEn          (regWrEn),
        .regWrData        (regWrData),
        .regRdData        (regRdData),
        .regRdValid       (regRdValid),
        .errorCountClear  (errorCountClear)
    );
    initial forever #2 core_clk = ~core_clk;
    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.read(a, d, v);
        chk("valid", 8'h01, {7'h0, v});
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic pulse(input logic [19:0] v, input int n);
        ev = v;
        repeat (n) @(negedge core_clk);
        ev = 20'h00000;
    endtask
    task automatic lane(input int l, input logic [11:0] c);
        rd(8'(8'h18 + 2 * l), c[7:0]);
        rd(8'(8'h19 + 2 * l), {4'h0, c[11:8]});
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        logic [7:0] d;
        logic       v;
        rstn = 1'b0;
        clkEn = 1'b1;
        powerdownMode = 1'b0;
        standbyMode = 1'b0;
        errorSourceSelect = 3'h0;
        laneVerifyEnable = 4'h0;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        for (int a = 'h18; a <= 'h21; a++) rd(8'(a), 8'h00);
        laneVerifyEnable = 4'hB;
        for (int s = 0; s < 8; s++) begin
            errorSourceSelect = 3'(s);
            host.setClear(1'b1);
            host.setClear(1'b0);
            pulse(~(20'hF << (4 * s)), 3);
            pulse(20'hF << (4 * s), s + 1);
            for (int l = 0; l < 4; l++) lane(l, 12'((s < 5 && l != 2) ? s + 1 : 0));
        end
        host.write(8'h1E, 8'hFF);
        host.write(8'h20, 8'hFF);
        rd(8'h1E, 8'h00);
        rd(8'h20, 8'h00);
        errorSourceSelect = 3'h0;
        laneVerifyEnable = 4'h1;
        host.setClear(1'b1);
        pulse(20'h00001, 5);
        host.setClear(1'b0);
        lane(0, 12'h005);
        // Frozen clock enable: errors are not counted and a read gets no answer
        clkEn = 1'b0;
        pulse(20'h00001, 3);
        host.read(8'h18, d, v);
        chk("valid", 8'h00, {7'h0, v});
        clkEn = 1'b1;
        lane(0, 12'h005);
        // Read in the cycle right after the clear edge
        host.setClear(1'b1);
        rd(8'h18, 8'h00);
        host.setClear(1'b0);
        pulse(20'h00001, 4100);
        lane(0, 12'hFFF);
        // Reset in mid-run returns the counters to zero
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        lane(0, 12'h000);
        powerdownMode = 1'b1;
        @(negedge core_clk);
        chk("powerdownFlag", 8'h01, {7'h0, powerdownFlag});
        rd(8'h20, 8'h80);
        powerdownMode = 1'b0;
        standbyMode = 1'b1;
        @(negedge core_clk);
        chk("standbyFlag", 8'h01, {7'h0, standbyFlag});
        chk("powerdownFlag", 8'h00, {7'h0, powerdownFlag});
        rd(8'h20, 8'h40);
        test_done;
    end
endmodule
